// File: include/ffs_pkg.sv
package ffs_pkg;

    localparam int REG_W = 8;
    localparam int ADDR_W = 8;
    localparam int NUM_PHASES = 4;
    localparam int SHORT_W = 5;

    localparam logic [ADDR_W-1:0] SHORT_FAULT_FLAGS_ADDR = 8'hd8;
    localparam logic [ADDR_W-1:0] OVERCURRENT_LEVEL1_PHASE_FLAGS_ADDR = 8'hd9;
    localparam logic [ADDR_W-1:0] OVERCURRENT_LEVEL2_PHASE_FLAGS_ADDR = 8'hda;

    localparam logic [REG_W-1:0] SHORT_FAULT_FLAGS_RST = 8'h00;
    localparam logic [REG_W-1:0] OVERCURRENT_LEVEL1_PHASE_FLAGS_RST = 8'h00;
    localparam logic [REG_W-1:0] OVERCURRENT_LEVEL2_PHASE_FLAGS_RST = 8'h00;

    // Short register bit positions
    localparam int HIGH_SIDE_SHORT_BIT = 0;
    localparam int LOW_VOLTAGE_BUS_SHORT_BIT = 1;
    localparam int LOW_SIDE_SHORT_BIT = 2;
    localparam int HIGH_VOLTAGE_BUS_SHORT_BIT = 3;
    localparam int FLYBACK_SHORT_BIT = 4;

    typedef enum logic [1:0] {
        SEL_SHORT = 2'b00,
        SEL_OCL1 = 2'b01,
        SEL_OCL2 = 2'b10,
        SEL_NONE = 2'b11
    } ffs_sel_type;

endpackage

// File: src/ffs_flag_reg.sv
`timescale 1ns/1ps
module ffs_flag_reg #(
    parameter int WIDTH = 4,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic clr_we,
    input wire logic [WIDTH-1:0] clr_mask,
    output logic [WIDTH-1:0] flags_q
);

    initial begin
        if (WIDTH < 1 || WIDTH > 8) begin
            $error("ffs_flag_reg: WIDTH must be 1 to 8");
        end
    end

    logic [WIDTH-1:0] flags_d;

    // Set wins over a clear in the same cycle
    always_comb begin
        flags_d = flags_q;
        if (clr_we) begin
            flags_d = flags_d & ~clr_mask;
        end
        flags_d = flags_d | set_in;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= RESET_VAL[WIDTH-1:0];
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule

// File: src/ffs_fault_flags.sv
`timescale 1ns/1ps
module ffs_fault_flags #(
    parameter int NUM_PHASES = ffs_pkg::NUM_PHASES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic high_side_short_det,
    input wire logic low_voltage_bus_short_det,
    input wire logic low_side_short_det,
    input wire logic high_voltage_bus_short_det,
    input wire logic flyback_short_det,
    input wire logic [NUM_PHASES-1:0] overcurrent_level_one_det,
    input wire logic [NUM_PHASES-1:0] negative_overcurrent_det,
    input wire logic [NUM_PHASES-1:0] overcurrent_level_two_det,
    input wire logic [ffs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [ffs_pkg::REG_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [ffs_pkg::REG_W-1:0] reg_rdata_q,
    output logic reg_rvalid_q,
    output logic reg_err_q,
    output logic [2:0] fault_summary_q
);

    initial begin
        if (NUM_PHASES != ffs_pkg::NUM_PHASES) begin
            $error("ffs_fault_flags: NUM_PHASES must be 4, the register holds four phase bits");
        end
    end

    // Address decode shared by reads and writes
    function automatic ffs_pkg::ffs_sel_type decode(input logic [ffs_pkg::ADDR_W-1:0] addr);
        ffs_pkg::ffs_sel_type sel;
        sel = ffs_pkg::SEL_NONE;
        if (addr == ffs_pkg::SHORT_FAULT_FLAGS_ADDR) begin
            sel = ffs_pkg::SEL_SHORT;
        end else if (addr == ffs_pkg::OVERCURRENT_LEVEL1_PHASE_FLAGS_ADDR) begin
            sel = ffs_pkg::SEL_OCL1;
        end else if (addr == ffs_pkg::OVERCURRENT_LEVEL2_PHASE_FLAGS_ADDR) begin
            sel = ffs_pkg::SEL_OCL2;
        end
        return sel;
    endfunction

    ffs_pkg::ffs_sel_type wr_sel;
    ffs_pkg::ffs_sel_type rd_sel;
    ffs_pkg::ffs_sel_type rd_sel_q;

    assign wr_sel = decode(reg_addr);
    assign rd_sel = decode(reg_addr);

    logic [ffs_pkg::SHORT_W-1:0] short_set;
    logic [NUM_PHASES-1:0] ocl1_set;
    logic [NUM_PHASES-1:0] ocl2_set;
    logic [ffs_pkg::SHORT_W-1:0] short_flags;
    logic [NUM_PHASES-1:0] ocl1_flags;
    logic [NUM_PHASES-1:0] ocl2_flags;

    always_comb begin
        short_set = '0;
        short_set[ffs_pkg::HIGH_SIDE_SHORT_BIT] = high_side_short_det;
        short_set[ffs_pkg::LOW_VOLTAGE_BUS_SHORT_BIT] = low_voltage_bus_short_det;
        short_set[ffs_pkg::LOW_SIDE_SHORT_BIT] = low_side_short_det;
        short_set[ffs_pkg::HIGH_VOLTAGE_BUS_SHORT_BIT] = high_voltage_bus_short_det;
        short_set[ffs_pkg::FLYBACK_SHORT_BIT] = flyback_short_det;
    end

    // Level one counts either polarity of overcurrent
    assign ocl1_set = overcurrent_level_one_det | negative_overcurrent_det;
    assign ocl2_set = overcurrent_level_two_det;

    ffs_flag_reg #(
        .WIDTH(ffs_pkg::SHORT_W),
        .RESET_VAL(ffs_pkg::SHORT_FAULT_FLAGS_RST)
    ) u_short (
        .clk(clk),
        .rstn(rstn),
        .set_in(short_set),
        .clr_we(reg_wr && wr_sel == ffs_pkg::SEL_SHORT),
        .clr_mask(reg_wdata[ffs_pkg::SHORT_W-1:0]),
        .flags_q(short_flags)
    );

    ffs_flag_reg #(
        .WIDTH(NUM_PHASES),
        .RESET_VAL(ffs_pkg::OVERCURRENT_LEVEL1_PHASE_FLAGS_RST)
    ) u_ocl1 (
        .clk(clk),
        .rstn(rstn),
        .set_in(ocl1_set),
        .clr_we(reg_wr && wr_sel == ffs_pkg::SEL_OCL1),
        .clr_mask(reg_wdata[NUM_PHASES-1:0]),
        .flags_q(ocl1_flags)
    );

    ffs_flag_reg #(
        .WIDTH(NUM_PHASES),
        .RESET_VAL(ffs_pkg::OVERCURRENT_LEVEL2_PHASE_FLAGS_RST)
    ) u_ocl2 (
        .clk(clk),
        .rstn(rstn),
        .set_in(ocl2_set),
        .clr_we(reg_wr && wr_sel == ffs_pkg::SEL_OCL2),
        .clr_mask(reg_wdata[NUM_PHASES-1:0]),
        .flags_q(ocl2_flags)
    );

    logic [ffs_pkg::REG_W-1:0] rd_mux;

    // Reserved bits zero-extended
    always_comb begin
        rd_mux = '0;
        unique case (rd_sel)
            ffs_pkg::SEL_SHORT: begin
                rd_mux = {{(ffs_pkg::REG_W-ffs_pkg::SHORT_W){1'b0}}, short_flags};
            end
            ffs_pkg::SEL_OCL1: begin
                rd_mux = {{(ffs_pkg::REG_W-NUM_PHASES){1'b0}}, ocl1_flags};
            end
            ffs_pkg::SEL_OCL2: begin
                rd_mux = {{(ffs_pkg::REG_W-NUM_PHASES){1'b0}}, ocl2_flags};
            end
            ffs_pkg::SEL_NONE: begin
                rd_mux = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata_q <= '0;
            reg_rvalid_q <= 1'b0;
            rd_sel_q <= ffs_pkg::SEL_NONE;
        end else begin
            reg_rvalid_q <= reg_rd;
            rd_sel_q <= rd_sel;
            if (reg_rd) begin
                reg_rdata_q <= rd_mux;
            end
        end
    end

    // Unmapped access answered with a one-cycle error pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_err_q <= 1'b0;
        end else begin
            reg_err_q <= (reg_rd || reg_wr) && wr_sel == ffs_pkg::SEL_NONE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_summary_q <= '0;
        end else begin
            fault_summary_q <= {|ocl2_flags, |ocl1_flags, |short_flags};
        end
    end

    sequence s_clear_short(int b);
        reg_wr && wr_sel == ffs_pkg::SEL_SHORT && reg_wdata[b];
    endsequence

    sequence s_read_of(ffs_pkg::ffs_sel_type s);
        reg_rd && !reg_wr && rd_sel == s;
    endsequence

    property p_high_side_set;
        @(posedge clk) disable iff (!rstn)
        high_side_short_det |=> short_flags[ffs_pkg::HIGH_SIDE_SHORT_BIT];
    endproperty
    a_high_side_set: assert property (p_high_side_set) else $error("high-side short not flagged");

    property p_low_voltage_bus_set;
        @(posedge clk) disable iff (!rstn)
        low_voltage_bus_short_det ##1 s_read_of(ffs_pkg::SEL_SHORT)
            |=> reg_rdata_q[ffs_pkg::LOW_VOLTAGE_BUS_SHORT_BIT];
    endproperty
    a_low_voltage_bus_set: assert property (p_low_voltage_bus_set) else $error("low bus short not read back");

    property p_low_side_set;
        @(posedge clk) disable iff (!rstn)
        low_side_short_det |=> short_flags[ffs_pkg::LOW_SIDE_SHORT_BIT];
    endproperty
    a_low_side_set: assert property (p_low_side_set) else $error("low-side short not flagged");

    property p_high_voltage_bus_set;
        @(posedge clk) disable iff (!rstn)
        high_voltage_bus_short_det |=> short_flags[ffs_pkg::HIGH_VOLTAGE_BUS_SHORT_BIT];
    endproperty
    a_high_voltage_bus_set: assert property (p_high_voltage_bus_set) else $error("high bus short not flagged");

    property p_flyback_set;
        @(posedge clk) disable iff (!rstn)
        flyback_short_det ##1 s_read_of(ffs_pkg::SEL_SHORT)
            |=> reg_rdata_q[ffs_pkg::FLYBACK_SHORT_BIT];
    endproperty
    a_flyback_set: assert property (p_flyback_set) else $error("flyback short not read back");

    property p_ocl1_either_polarity;
        @(posedge clk) disable iff (!rstn)
        (negative_overcurrent_det[0] && !overcurrent_level_one_det[0]) |=> ocl1_flags[0];
    endproperty
    a_ocl1_either_polarity: assert property (p_ocl1_either_polarity) else $error("negative overcurrent missed");

    property p_ocl1_phase4;
        @(posedge clk) disable iff (!rstn)
        overcurrent_level_one_det[NUM_PHASES-1] ##1 s_read_of(ffs_pkg::SEL_OCL1)
            |=> reg_rdata_q[NUM_PHASES-1];
    endproperty
    a_ocl1_phase4: assert property (p_ocl1_phase4) else $error("phase 4 level one missed");

    property p_ocl1_reserved;
        @(posedge clk) disable iff (!rstn)
        reg_rvalid_q && rd_sel_q == ffs_pkg::SEL_OCL1 |-> reg_rdata_q[7:4] == 4'h0;
    endproperty
    a_ocl1_reserved: assert property (p_ocl1_reserved) else $error("level one reserved bits set");

    property p_ocl2_phase1;
        @(posedge clk) disable iff (!rstn)
        overcurrent_level_two_det[0] |=> ocl2_flags[0];
    endproperty
    a_ocl2_phase1: assert property (p_ocl2_phase1) else $error("phase 1 level two missed");

    property p_ocl2_reserved;
        @(posedge clk) disable iff (!rstn)
        reg_rvalid_q && rd_sel_q == ffs_pkg::SEL_OCL2 |-> reg_rdata_q[7:4] == 4'h0;
    endproperty
    a_ocl2_reserved: assert property (p_ocl2_reserved) else $error("level two reserved bits set");

    property p_ocl2_phase4;
        @(posedge clk) disable iff (!rstn)
        overcurrent_level_two_det[3] |=> ocl2_flags[3] ##1 fault_summary_q[2];
    endproperty
    a_ocl2_phase4: assert property (p_ocl2_phase4) else $error("phase 4 level two missed");

    property p_short_reserved;
        @(posedge clk) disable iff (!rstn)
        reg_rvalid_q && rd_sel_q == ffs_pkg::SEL_SHORT |-> reg_rdata_q[7:5] == 3'h0;
    endproperty
    a_short_reserved: assert property (p_short_reserved) else $error("short reserved bits set");

    property p_sticky_hold;
        @(posedge clk) disable iff (!rstn)
        ocl1_flags[1] && !(reg_wr && wr_sel == ffs_pkg::SEL_OCL1 && reg_wdata[1]) |=> ocl1_flags[1];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("flag dropped without clear");

    property p_clear_works;
        @(posedge clk) disable iff (!rstn)
        s_clear_short(0) and !high_side_short_det |=> !short_flags[0];
    endproperty
    a_clear_works: assert property (p_clear_works) else $error("clear write ignored");

    property p_set_beats_clear;
        @(posedge clk) disable iff (!rstn)
        s_clear_short(4) and flyback_short_det |=> short_flags[4];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("set lost to clear");

endmodule

// File: sim/ffs_ctrl_model.sv
`timescale 1ns/1ps
module ffs_ctrl_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic reg_rvalid_q,
    input wire logic reg_err_q
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // Strobe held for one edge; afterwards the lines stop showing the old value
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v, output logic e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata_q;
        v = reg_rvalid_q;
        e = reg_err_q;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~w;
    endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [4:0] sh;
        logic [3:0] o1;
        logic [3:0] nc;
        logic [3:0] o2;
    } ffs_row_type;
    logic clk;
    logic rstn;
    logic [4:0] sh;
    logic [3:0] o1;
    logic [3:0] nc;
    logic [3:0] o2;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic reg_rd;
    logic [7:0] reg_rdata_q;
    logic reg_rvalid_q;
    logic reg_err_q;
    logic [2:0] fault_summary_q;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    ffs_row_type rows [5] = '{'{5'h01, 4'h1, 4'h0, 4'h1}, '{5'h02, 4'h0, 4'h2, 4'h2},
        '{5'h04, 4'h4, 4'h0, 4'h4}, '{5'h08, 4'h0, 4'h8, 4'h8}, '{5'h10, 4'h0, 4'h0, 4'h0}};

    ffs_fault_flags i_ffs_fault_flags (.clk(clk), .rstn(rstn), .high_side_short_det(sh[0]),
        .low_voltage_bus_short_det(sh[1]), .low_side_short_det(sh[2]), .high_voltage_bus_short_det(sh[3]),
        .flyback_short_det(sh[4]), .overcurrent_level_one_det(o1), .negative_overcurrent_det(nc),
        .overcurrent_level_two_det(o2), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .reg_err_q(reg_err_q),
        .fault_summary_q(fault_summary_q));
    ffs_ctrl_model i_ffs_ctrl_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .reg_err_q(reg_err_q));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic test_done();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Read with data, valid and error checked; err selects the refused outcome
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic err);
        logic [7:0] d;
        logic v;
        logic e;
        i_ffs_ctrl_model.rd(a, d, v, e);
        check(d, exp);
        check({6'h00, v, e}, err ? 8'h03 : 8'h02);
    endtask

    task automatic pulse(input logic [4:0] s, input logic [3:0] a, input logic [3:0] n, input logic [3:0] b);
        @(posedge clk);
        sh <= s;
        o1 <= a;
        nc <= n;
        o2 <= b;
        @(posedge clk);
        sh <= 5'h00;
        o1 <= 4'h0;
        nc <= 4'h0;
        o2 <= 4'h0;
        repeat (2) @(posedge clk);
    endtask

    initial begin
        rstn = 1'b0;
        sh = 5'h00;
        o1 = 4'h0;
        nc = 4'h0;
        o2 = 4'h0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rdchk(8'hd8, 8'h00, 1'b0);
        rdchk(8'hd9, 8'h00, 1'b0);
        rdchk(8'hda, 8'h00, 1'b0);
        foreach (rows[i]) begin
            // Detects last one cycle; flags must still be up when read
            pulse(rows[i].sh, rows[i].o1, rows[i].nc, rows[i].o2);
            rdchk(8'hd8, {3'h0, rows[i].sh}, 1'b0);
            rdchk(8'hd9, {4'h0, rows[i].o1 | rows[i].nc}, 1'b0);
            rdchk(8'hda, {4'h0, rows[i].o2}, 1'b0);
            for (int k = 0; k < 3; k++) begin
                i_ffs_ctrl_model.wr(8'hd8 + 8'(k), 8'hff);
                rdchk(8'hd8 + 8'(k), 8'h00, 1'b0);
            end
        end
        // Detects still high while read and while a clear is written
        @(posedge clk);
        sh <= 5'h12;
        o1 <= 4'h8;
        nc <= 4'h1;
        rdchk(8'hd8, 8'h12, 1'b0);
        rdchk(8'hd9, 8'h09, 1'b0);
        i_ffs_ctrl_model.wr(8'hd8, 8'hff);
        rdchk(8'hd8, 8'h12, 1'b0);
        @(posedge clk);
        sh <= 5'h00;
        o1 <= 4'h0;
        nc <= 4'h0;
        i_ffs_ctrl_model.wr(8'hd8, 8'hff);
        rdchk(8'hd8, 8'h00, 1'b0);
        i_ffs_ctrl_model.wr(8'hd9, 8'hff);
        rdchk(8'hd9, 8'h00, 1'b0);
        pulse(5'h1f, 4'h5, 4'ha, 4'hf);
        #1;
        check({5'h00, fault_summary_q}, 8'h07);
        i_ffs_ctrl_model.wr(8'hd9, 8'h01);
        rdchk(8'hd9, 8'h0e, 1'b0);
        i_ffs_ctrl_model.wr(8'hda, 8'hf0);
        rdchk(8'hda, 8'h0f, 1'b0);
        i_ffs_ctrl_model.wr(8'hdb, 8'hff);
        rdchk(8'hdb, 8'h00, 1'b1);
        rdchk(8'hd8, 8'h1f, 1'b0);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rdchk(8'hd8, 8'h00, 1'b0);
        rdchk(8'hd9, 8'h00, 1'b0);
        rdchk(8'hda, 8'h00, 1'b0);
        test_done();
    end
endmodule
